// ===== rtl/legacy_data_link_byte_port.sv
// Purpose: Legacy T1 facility link byte port, receive and transmit
// Assumes: Framer bit strobes run on ref_clk; host port is synchronous
// Notes:   Transmit bytes pass a small FIFO before the serializer
// Operation
// - Each received link or Fs bit, except a dropped stuffed zero, shifts into an 8-bit receive byte.
// - Receive-full flag sets whenever eight bits have been collected.
// - Unmasked receive-full flag pulls the interrupt output low.
// - Completed byte equal to either match byte sets match flag, may interrupt.
// - With destuffing on, a zero after exactly five ones is dropped.
// - A zero after six or more ones is kept.
// - First received bit lands in the LSB, last in the MSB.
// - A written transmit byte goes out LSB first, link or Fs positions.
// - After eight bits are sent the transmit-empty flag sets.
// - Unmasked transmit-empty flag pulls the interrupt output low.
// - Without a new write the previous byte is sent again.
// - With stuffing on, a zero follows every run of five ones.
// - In D4 mode the transmit byte also sources the Fs pattern.
`timescale 1ns/1ps
module legacy_data_link_byte_port
    import link_port_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic [7:0] cpu_addr,
    input  wire logic [7:0] cpu_wdata,
    input  wire logic       cpu_wr,
    input  wire logic       cpu_rd,
    output logic      [7:0] cpu_rdata_r,
    output logic            int_n_r,
    input  wire logic       rx_link_bit,
    input  wire logic       rx_link_strobe,
    input  wire logic       tx_link_req,
    output logic            tx_link_bit_r,
    output logic            tx_fs_select_r,
    output logic            tx_byte_ready_r
);
    logic [7:0] rx_link_byte_r;
    logic [7:0] tx_link_byte_r;
    logic [7:0] rx_link_match_one_r;
    logic [7:0] rx_link_match_two_r;
    logic [7:0] link_interrupt_mask_reg_r;
    logic [7:0] link_control_r;
    logic [3:0] status_r;
    logic [7:0] rx_shift_r;
    logic [2:0] rx_count_r;
    logic [2:0] rx_ones_r;
    logic [7:0] tx_cur_r;
    logic [2:0] tx_idx_r;
    logic [2:0] tx_ones_r;
    logic       wr_tx;
    logic       rd_status;
    logic       destuff_en;
    logic       stuff_en;
    logic       rx_drop;
    logic       rx_take;
    logic       rx_done;
    logic [7:0] rx_shift_nxt;
    logic       rx_match;
    logic       tx_stuff;
    logic       tx_done;
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic [3:0] status_set;

    assign wr_tx      = cpu_wr && (cpu_addr == TX_BYTE_ADDR);
    assign rd_status  = cpu_rd && (cpu_addr == STATUS_ADDR);
    assign destuff_en = link_control_r[CTL_DESTUFF_BIT];
    assign stuff_en   = link_control_r[CTL_STUFF_BIT];

    // Receive bit path
    assign rx_drop      = destuff_en && !rx_link_bit && (rx_ones_r == STUFF_RUN);
    assign rx_take      = rx_link_strobe && !rx_drop;
    assign rx_shift_nxt = {rx_link_bit, rx_shift_r[7:1]};
    assign rx_done      = rx_take && (rx_count_r == LAST_BIT);
    assign rx_match     = (rx_shift_nxt == rx_link_match_one_r) || (rx_shift_nxt == rx_link_match_two_r);

    // Transmit bit path
    assign tx_stuff = stuff_en && (tx_ones_r == STUFF_RUN);
    assign tx_done  = tx_link_req && !tx_stuff && (tx_idx_r == LAST_BIT);

    assign status_set[0]               = 1'b0;
    assign status_set[ST_MATCH_BIT]    = rx_done && rx_match;
    assign status_set[ST_TX_EMPTY_BIT] = tx_done;
    assign status_set[ST_RX_FULL_BIT]  = rx_done;

    link_byte_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .in_valid  (wr_tx),
        .in_ready  (fifo_in_ready),
        .in_data   (cpu_wdata),
        .out_valid (fifo_out_valid),
        .out_ready (tx_done),
        .out_data  (fifo_out_data)
    );

    // Host-written registers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tx_link_byte_r            <= BYTE_RESET;
            rx_link_match_one_r       <= BYTE_RESET;
            rx_link_match_two_r       <= BYTE_RESET;
            link_interrupt_mask_reg_r <= BYTE_RESET;
            link_control_r            <= BYTE_RESET;
        end else if (cpu_wr) begin
            unique case (cpu_addr)
                TX_BYTE_ADDR: begin
                    if (fifo_in_ready) begin
                        tx_link_byte_r <= cpu_wdata;
                    end
                end
                MATCH_ONE_ADDR: rx_link_match_one_r       <= cpu_wdata;
                MATCH_TWO_ADDR: rx_link_match_two_r       <= cpu_wdata;
                MASK_ADDR:      link_interrupt_mask_reg_r <= cpu_wdata;
                CONTROL_ADDR:   link_control_r            <= cpu_wdata;
                default: ;
            endcase
        end
    end

    // Read data
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cpu_rdata_r <= READ_ZERO;
        end else if (cpu_rd) begin
            unique case (cpu_addr)
                RX_BYTE_ADDR:   cpu_rdata_r <= rx_link_byte_r;
                TX_BYTE_ADDR:   cpu_rdata_r <= tx_link_byte_r;
                MATCH_ONE_ADDR: cpu_rdata_r <= rx_link_match_one_r;
                MATCH_TWO_ADDR: cpu_rdata_r <= rx_link_match_two_r;
                STATUS_ADDR:    cpu_rdata_r <= {4'h0, status_r};
                MASK_ADDR:      cpu_rdata_r <= link_interrupt_mask_reg_r;
                CONTROL_ADDR:   cpu_rdata_r <= link_control_r;
                default:        cpu_rdata_r <= READ_ZERO;
            endcase
        end
    end

    // Receive shifter and byte register
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rx_shift_r     <= BYTE_RESET;
            rx_count_r     <= '0;
            rx_link_byte_r <= BYTE_RESET;
        end else if (rx_take) begin
            rx_shift_r <= rx_shift_nxt;
            rx_count_r <= rx_count_r + 3'h1;
            if (rx_done) begin
                rx_link_byte_r <= rx_shift_nxt;
            end
        end
    end

    // Run of ones seen on receive
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rx_ones_r <= '0;
        end else if (rx_link_strobe) begin
            if (!rx_link_bit) begin
                rx_ones_r <= '0;
            end else if (rx_ones_r != ONES_SAT) begin
                rx_ones_r <= rx_ones_r + 3'h1;
            end
        end
    end

    // Transmit serializer
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tx_cur_r      <= BYTE_RESET;
            tx_idx_r      <= '0;
            tx_ones_r     <= '0;
            tx_link_bit_r <= 1'b0;
        end else if (tx_link_req) begin
            if (tx_stuff) begin
                tx_link_bit_r <= 1'b0;
                tx_ones_r     <= '0;
            end else begin
                tx_link_bit_r <= tx_cur_r[tx_idx_r];
                tx_ones_r     <= !tx_cur_r[tx_idx_r] ? 3'h0 : (tx_ones_r == ONES_SAT) ? ONES_SAT : tx_ones_r + 3'h1;
                tx_idx_r      <= tx_idx_r + 3'h1;
                if (tx_done && fifo_out_valid) begin
                    tx_cur_r <= fifo_out_data;
                end
            end
        end
    end

    // Latched status, set wins over read clear
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            status_r <= '0;
        end else if (rd_status) begin
            status_r <= status_set;
        end else begin
            status_r <= status_r | status_set;
        end
    end

    // Interrupt and side outputs
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            int_n_r         <= 1'b1;
            tx_fs_select_r  <= 1'b0;
            tx_byte_ready_r <= 1'b0;
        end else begin
            int_n_r         <= ~|(status_r & link_interrupt_mask_reg_r[3:0]);
            tx_fs_select_r  <= link_control_r[CTL_D4_BIT];
            tx_byte_ready_r <= fifo_in_ready;
        end
    end

    AST_RX_SHIFT: assert property (@(posedge ref_clk) disable iff (reset)
        rx_take |=> rx_shift_r[7] == $past(rx_link_bit))
        else $error("Receive bit not shifted in");
    AST_RX_FULL: assert property (@(posedge ref_clk) disable iff (reset)
        rx_done |=> status_r[ST_RX_FULL_BIT] ##1 !int_n_r || !link_interrupt_mask_reg_r[ST_RX_FULL_BIT])
        else $error("Receive full not flagged");
    AST_INT_RX: assert property (@(posedge ref_clk) disable iff (reset)
        (status_r[ST_RX_FULL_BIT] && link_interrupt_mask_reg_r[ST_RX_FULL_BIT]) |=> !int_n_r)
        else $error("Receive full interrupt missing");
    AST_MATCH: assert property (@(posedge ref_clk) disable iff (reset)
        (rx_done && rx_match) |=> status_r[ST_MATCH_BIT])
        else $error("Match flag not set");
    AST_DESTUFF: assert property (@(posedge ref_clk) disable iff (reset)
        (rx_link_strobe && rx_drop) |=> $stable(rx_count_r) && $stable(rx_shift_r))
        else $error("Stuffed zero not removed");
    AST_KEEP_ZERO: assert property (@(posedge ref_clk) disable iff (reset)
        (rx_link_strobe && !rx_link_bit && rx_ones_r >= 3'h6) |=> rx_count_r == $past(rx_count_r) + 3'h1)
        else $error("Zero after six ones dropped");
    AST_LSB_FIRST: assert property (@(posedge ref_clk) disable iff (reset)
        rx_done |=> rx_link_byte_r == {$past(rx_link_bit), $past(rx_shift_r[7:1])})
        else $error("Receive byte order wrong");
    AST_TX_EMPTY: assert property (@(posedge ref_clk) disable iff (reset)
        tx_done |=> status_r[ST_TX_EMPTY_BIT] && tx_idx_r == 3'h0)
        else $error("Transmit empty not flagged");
    AST_INT_TX: assert property (@(posedge ref_clk) disable iff (reset)
        (status_r[ST_TX_EMPTY_BIT] && link_interrupt_mask_reg_r[ST_TX_EMPTY_BIT]) |=> !int_n_r)
        else $error("Transmit empty interrupt missing");
    AST_REPEAT: assert property (@(posedge ref_clk) disable iff (reset)
        (tx_done && !fifo_out_valid) |=> $stable(tx_cur_r))
        else $error("Previous byte not repeated");
    AST_STUFF: assert property (@(posedge ref_clk) disable iff (reset)
        (tx_link_req && tx_stuff) |=> !tx_link_bit_r && tx_ones_r == 3'h0 && $stable(tx_idx_r))
        else $error("Zero not stuffed after five ones");
    AST_CLEAR: assert property (@(posedge ref_clk) disable iff (reset)
        (rd_status && status_set == 4'h0) |=> status_r == 4'h0)
        else $error("Status not cleared by read");
    AST_RX_IDLE: assert property (@(posedge ref_clk) disable iff (reset)
        !rx_take |=> $stable(rx_count_r) && $stable(rx_shift_r))
        else $error("Receive shifter moved without a bit");
    AST_RX_STEP: assert property (@(posedge ref_clk) disable iff (reset)
        rx_take |=> rx_count_r == $past(rx_count_r) + 3'h1)
        else $error("Receive bit count did not advance");
    AST_RX_BYTE_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
        !rx_done |=> $stable(rx_link_byte_r))
        else $error("Receive byte changed before it was full");
    AST_INT_MATCH: assert property (@(posedge ref_clk) disable iff (reset)
        (status_r[ST_MATCH_BIT] && link_interrupt_mask_reg_r[ST_MATCH_BIT]) |=> !int_n_r)
        else $error("Match interrupt missing");
    AST_NO_MATCH: assert property (@(posedge ref_clk) disable iff (reset)
        (rx_done && !rx_match && !status_r[ST_MATCH_BIT]) |=> !status_r[ST_MATCH_BIT])
        else $error("Match flag set without a match");
    AST_INT_QUIET: assert property (@(posedge ref_clk) disable iff (reset)
        ((status_r & link_interrupt_mask_reg_r[3:0]) == 4'h0) |=> int_n_r)
        else $error("Interrupt without an unmasked flag");
    AST_TX_BIT: assert property (@(posedge ref_clk) disable iff (reset)
        (tx_link_req && !tx_stuff) |=> tx_link_bit_r == $past(tx_cur_r[tx_idx_r]))
        else $error("Transmit bit not taken from current byte");
    AST_TX_STEP: assert property (@(posedge ref_clk) disable iff (reset)
        (tx_link_req && !tx_stuff) |=> tx_idx_r == $past(tx_idx_r) + 3'h1)
        else $error("Transmit bit index did not advance");
    AST_TX_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
        !tx_link_req |=> $stable(tx_link_bit_r) && $stable(tx_idx_r))
        else $error("Transmit bit changed without a request");
    AST_TX_LOAD: assert property (@(posedge ref_clk) disable iff (reset)
        (tx_done && fifo_out_valid) |=> tx_cur_r == $past(fifo_out_data))
        else $error("New transmit byte not loaded");
    AST_NO_STUFF: assert property (@(posedge ref_clk) disable iff (reset)
        (tx_link_req && !stuff_en) |=> tx_idx_r == $past(tx_idx_r) + 3'h1)
        else $error("Zero stuffed while stuffing is off");
    AST_FS_SELECT: assert property (@(posedge ref_clk) disable iff (reset)
        1'b1 |=> tx_fs_select_r == $past(link_control_r[CTL_D4_BIT]))
        else $error("Fs source select does not follow mode");
    AST_FLAG_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
        !rd_status |=> (status_r & $past(status_r)) == $past(status_r))
        else $error("Status flag lost without a read");
    AST_STATUS_READ: assert property (@(posedge ref_clk) disable iff (reset)
        (cpu_rd && cpu_addr == STATUS_ADDR) |=> cpu_rdata_r == {4'h0, $past(status_r)})
        else $error("Status read returned wrong flags");
endmodule // legacy_data_link_byte_port

// ===== rtl/link_port_pkg.sv
// Purpose: Shared constants of the legacy data link byte port
// Assumes: 8-bit parallel register port, byte addresses
// Notes:   Status and mask reuse the same bit positions
package link_port_pkg;
    localparam logic [7:0] RX_BYTE_ADDR   = 8'hc0;
    localparam logic [7:0] TX_BYTE_ADDR   = 8'hc1;
    localparam logic [7:0] MATCH_ONE_ADDR = 8'hc2;
    localparam logic [7:0] MATCH_TWO_ADDR = 8'hc3;
    localparam logic [7:0] STATUS_ADDR    = 8'hc4;
    localparam logic [7:0] MASK_ADDR      = 8'hc5;
    localparam logic [7:0] CONTROL_ADDR   = 8'hc6;

    localparam int ST_MATCH_BIT    = 1;
    localparam int ST_TX_EMPTY_BIT = 2;
    localparam int ST_RX_FULL_BIT  = 3;

    localparam int CTL_DESTUFF_BIT = 0;
    localparam int CTL_STUFF_BIT   = 1;
    localparam int CTL_D4_BIT      = 2;

    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO  = 8'h00;
    localparam logic [2:0] STUFF_RUN  = 3'h5;
    localparam logic [2:0] ONES_SAT   = 3'h7;
    localparam logic [2:0] LAST_BIT   = 3'h7;
endpackage

// ===== rtl/link_byte_fifo.sv
// Purpose: Small valid/ready byte FIFO
// Assumes: DEPTH is a power of two
// Notes:   Simultaneous push and pop allowed when neither empty nor full
`timescale 1ns/1ps
module link_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr_r;
    logic [PW-1:0]    rd_ptr_r;
    logic [CW-1:0]    count_r;
    logic             push;
    logic             pop;

    assign in_ready  = (count_r != CW'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data  = mem[rd_ptr_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + PW'(1);
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + PW'(1);
            end
            if (push && !pop) begin
                count_r <= count_r + CW'(1);
            end else if (pop && !push) begin
                count_r <= count_r - CW'(1);
            end
        end
    end
endmodule // link_byte_fifo

// ===== testbench/link_framer_model.sv
// Purpose: Framer side of the link byte port
// Assumes: One bit per strobe or request
// Notes:   Idle data line shows the inverted last bit
`timescale 1ns/1ps
module link_framer_model (
    input  wire logic ref_clk,
    input  wire logic tx_link_bit_r,
    output logic      rx_link_bit,
    output logic      rx_link_strobe,
    output logic      tx_link_req
);
    initial begin
        rx_link_bit    = 1'b0;
        rx_link_strobe = 1'b0;
        tx_link_req    = 1'b0;
    end
    task automatic send_bit(input logic b);
        @(posedge ref_clk);
        rx_link_strobe <= 1'b1;
        rx_link_bit    <= b;
        @(posedge ref_clk);
        rx_link_strobe <= 1'b0;
        rx_link_bit    <= ~b;
    endtask
    task automatic take_bit(output logic b);
        @(posedge ref_clk);
        tx_link_req <= 1'b1;
        @(posedge ref_clk);
        tx_link_req <= 1'b0;
        @(posedge ref_clk);
        #1 b = tx_link_bit_r;
    endtask
endmodule // link_framer_model

// ===== testbench/legacy_data_link_byte_port_tb.sv
// Purpose: Self-checking bench of the link byte port
// Assumes: Host and framer act on rising edges
// Notes:   Reference models track rx shift and tx serializer
`timescale 1ns/1ps
module legacy_data_link_byte_port_tb;
    import link_port_pkg::*;
    logic       ref_clk   = 1'b0;
    logic       reset     = 1'b1;
    logic [7:0] cpu_addr  = 8'h00;
    logic [7:0] cpu_wdata = 8'h00;
    logic       cpu_wr    = 1'b0;
    logic       cpu_rd    = 1'b0;
    logic [7:0] cpu_rdata_r;
    logic       int_n_r, rx_link_bit, rx_link_strobe, tx_link_req;
    logic       tx_link_bit_r, tx_fs_select_r, tx_byte_ready_r, b;
    logic [7:0] ctl = 8'h00, msk = 8'h00, m1, m2, sh, cur = 8'h00, rd, v;
    logic [7:0] fifo[$];
    int         n_mismatch = 0, n_checks = 0;
    int         rcnt = 0, rones = 0, tidx = 0, tones = 0;
    always #5 ref_clk = ~ref_clk;
    legacy_data_link_byte_port #(.FIFO_DEPTH(4)) u_legacy_data_link_byte_port (.ref_clk, .reset, .cpu_addr,
        .cpu_wdata, .cpu_wr, .cpu_rd, .cpu_rdata_r, .int_n_r, .rx_link_bit, .rx_link_strobe,
        .tx_link_req, .tx_link_bit_r, .tx_fs_select_r, .tx_byte_ready_r);
    link_framer_model u_link_framer_model (.ref_clk, .tx_link_bit_r, .rx_link_bit, .rx_link_strobe,
        .tx_link_req);
    function automatic logic [7:0] exp_rx_status(logic [7:0] val);
        return {4'h0, 1'b1, 1'b0, (val == m1 || val == m2), 1'b0};
    endfunction
    task automatic check_byte(string nm, logic [7:0] e, logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check_bit(string nm, logic e, logic g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge ref_clk);
        cpu_wr    <= 1'b1;
        cpu_addr  <= a;
        cpu_wdata <= d;
        @(posedge ref_clk);
        cpu_wr <= 1'b0;
    endtask
    task automatic rdr(logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        cpu_rd   <= 1'b1;
        cpu_addr <= a;
        @(posedge ref_clk);
        cpu_rd <= 1'b0;
        @(posedge ref_clk);
        #1 d = cpu_rdata_r;
    endtask
    // Host side: every full byte is read well within its time
    task automatic rx(logic bt);
        u_link_framer_model.send_bit(bt);
        if (!bt && rones == 5 && ctl[CTL_DESTUFF_BIT]) begin
            rones = 0;
            return;
        end
        rones = bt ? (rones == 7 ? 7 : rones + 1) : 0;
        sh = {bt, sh[7:1]};
        rcnt++;
        if (rcnt == 8) begin
            rcnt = 0;
            repeat (2) @(posedge ref_clk);
            #1 check_bit("int_n_rx", !msk[ST_RX_FULL_BIT], int_n_r);
            rdr(RX_BYTE_ADDR, rd);
            check_byte("rx_byte", sh, rd);
            rdr(STATUS_ADDR, rd);
            check_byte("status_rx", exp_rx_status(sh), rd);
            rdr(STATUS_ADDR, rd);
            check_byte("status_clr", 8'h00, rd);
            check_bit("int_n_clr", 1'b1, int_n_r);
        end
    endtask
    task automatic tx(int n);
        repeat (n) begin
            u_link_framer_model.take_bit(b);
            if (ctl[CTL_STUFF_BIT] && tones == 5) begin
                check_bit("tx_stuff", 1'b0, b);
                tones = 0;
            end else begin
                check_bit("tx_bit", cur[tidx], b);
                tones = cur[tidx] ? (tones == 7 ? 7 : tones + 1) : 0;
                tidx = (tidx + 1) % 8;
                if (tidx == 0 && fifo.size() > 0) cur = fifo.pop_front();
            end
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #500000;
        n_mismatch++;
        summarize();
    end
    initial begin
        void'($urandom(32'ha90c));
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 check_bit("byte_ready", 1'b1, tx_byte_ready_r);
        check_bit("fs_select_rst", 1'b0, tx_fs_select_r);
        for (int a = 8'hc0; a <= 8'hc7; a++) begin
            rdr(8'(a), rd);
            check_byte("reset_value", 8'h00, rd);
        end
        m1 = 8'($urandom);
        m2 = 8'($urandom);
        wr(MATCH_ONE_ADDR, m1);
        wr(MATCH_TWO_ADDR, m2);
        wr(RX_BYTE_ADDR, 8'h5a);
        wr(8'hc7, 8'h33);
        rdr(MATCH_ONE_ADDR, rd);
        check_byte("match_one", m1, rd);
        rdr(MATCH_TWO_ADDR, rd);
        check_byte("match_two", m2, rd);
        rdr(RX_BYTE_ADDR, rd);
        check_byte("rx_ro", 8'h00, rd);
        $display("test registers done");
        msk = 8'h0a;
        wr(MASK_ADDR, msk);
        for (int i = 0; i < 6; i++) begin
            v = (i == 1) ? m1 : (i == 2) ? m2 : 8'($urandom);
            for (int k = 0; k < 8; k++) rx(v[k]);
        end
        $display("test rx_plain done");
        ctl = 8'h01;
        wr(CONTROL_ADDR, ctl);
        for (int n = 5; n <= 7; n++) begin
            rx(1'b0);
            repeat (n) rx(1'b1);
            rx(1'b0);
            repeat (10) rx(1'($urandom));
        end
        repeat (8 - rcnt) rx(1'b1);
        $display("test rx_destuff done");
        ctl = 8'h00;
        msk = 8'h04;
        wr(CONTROL_ADDR, ctl);
        wr(MASK_ADDR, msk);
        tx(8);
        repeat (2) @(posedge ref_clk);
        #1 check_bit("int_n_tx", 1'b0, int_n_r);
        rdr(STATUS_ADDR, rd);
        check_byte("status_tx", 8'h04, rd);
        for (int i = 0; i < 5; i++) begin
            v = 8'($urandom);
            wr(TX_BYTE_ADDR, v);
            if (fifo.size() < 4) fifo.push_back(v);
        end
        repeat (2) @(posedge ref_clk);
        #1 check_bit("byte_full", 1'b0, tx_byte_ready_r);
        rdr(TX_BYTE_ADDR, rd);
        check_byte("tx_byte", fifo[3], rd);
        tx(48);
        check_bit("byte_drain", 1'b1, tx_byte_ready_r);
        $display("test tx_fifo done");
        ctl = 8'h02;
        wr(CONTROL_ADDR, ctl);
        wr(TX_BYTE_ADDR, 8'hff);
        fifo.push_back(8'hff);
        wr(TX_BYTE_ADDR, 8'hbf);
        fifo.push_back(8'hbf);
        tx(30);
        $display("test tx_stuff done");
        ctl = 8'h04;
        wr(CONTROL_ADDR, ctl);
        wr(TX_BYTE_ADDR, 8'h1c);
        fifo.push_back(8'h1c);
        #1 check_bit("fs_select", 1'b1, tx_fs_select_r);
        tx(24);
        $display("test tx_d4 done");
        summarize();
    end
endmodule // legacy_data_link_byte_port_tb
